/* core/eim_pkg.sv */
package eim_pkg;
   localparam int NUM_WAIT = 6;
   localparam int MAXW_W = 8;
   localparam int ADDR_W = 8;
   localparam int STAT_W = 6;

   // Register byte offsets
   localparam logic [7:0] RAW_OFS    = 8'h00;
   localparam logic [7:0] MASKED_OFS = 8'h04;
   localparam logic [7:0] ENSET_OFS  = 8'h08;
   localparam logic [7:0] ENCLR_OFS  = 8'h0C;
   localparam logic [7:0] CFG_OFS    = 8'h10;

   // Field positions
   localparam int TMO_BIT = 0;
   localparam int RSV_BIT = 1;
   localparam int WR_LO   = 2;
   localparam int WR_HI   = 5;

   // Implemented bits of the status and enable registers
   localparam logic [5:0] FIELD_MASK = 6'h3D;

   // Values after reset
   localparam logic [5:0] STAT_RST = 6'h00;
   localparam logic [5:0] EN_RST   = 6'h00;
   localparam logic [7:0] MAXW_RST = 8'h80;

   typedef enum logic [2:0] {
      REG_RAW    = 3'd0,
      REG_MASKED = 3'd1,
      REG_ENSET  = 3'd2,
      REG_ENCLR  = 3'd3,
      REG_CFG    = 3'd4,
      REG_NONE   = 3'd7
   } eim_reg_t;

   typedef enum logic [1:0] {
      TMO_IDLE  = 2'b00,
      TMO_COUNT = 2'b01,
      TMO_FIRED = 2'b11
   } eim_tmo_state_t;

   function automatic eim_reg_t eim_decode(input logic [7:0] a);
      case (a)
         RAW_OFS:    return REG_RAW;
         MASKED_OFS: return REG_MASKED;
         ENSET_OFS:  return REG_ENSET;
         ENCLR_OFS:  return REG_ENCLR;
         CFG_OFS:    return REG_CFG;
         default:    return REG_NONE;
      endcase
   endfunction
endpackage

/* core/eim_evt_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface eim_evt_if #(parameter int N = 6);
   logic [N-1:0] waitLevel;
   logic [N-1:0] waitRise;
   logic         timeout;

   modport edge_src (output waitLevel, output waitRise);
   modport tmo_src  (input waitLevel, output timeout);
   modport snk      (input waitRise, input timeout);
endinterface
`default_nettype wire

/* core/eim_wait_edge.sv */
`timescale 1ns/1ps
`default_nettype none
module eim_wait_edge
   import eim_pkg::*;
#(
   parameter int N = NUM_WAIT
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         arst_n,
   // Wait pins
   input  wire logic [N-1:0] memWait,
   // Events
   eim_evt_if.edge_src       evt
);
   logic [N-1:0] sync1;
   logic [N-1:0] sync2;
   logic [N-1:0] prev;

   if (N < 6) begin : g_chk
      $error("eim_wait_edge needs at least six wait inputs");
   end

   // Pins are asynchronous, two flops before any logic
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1 <= '0;
         sync2 <= '0;
         prev  <= '0;
      end else begin
         sync1 <= memWait;
         sync2 <= sync1;
         prev  <= sync2;
      end
   end

   assign evt.waitLevel = sync2;

   for (genvar i = 0; i < N; i++) begin : g_rise
      assign evt.waitRise[i] = sync2[i] & ~prev[i];
   end
endmodule
`default_nettype wire

/* core/eim_timeout.sv */
`timescale 1ns/1ps
`default_nettype none
module eim_timeout
   import eim_pkg::*;
#(
   parameter int N = NUM_WAIT,
   parameter int W = MAXW_W
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         arst_n,
   // Access from the memory sequencer, wait limit from the CFG register
   input  wire logic         extAccessActive,
   input  wire logic [2:0]   extWaitSel,
   input  wire logic [W-1:0] maxWait,
   // Events
   eim_evt_if.tmo_src        evt
);
   eim_tmo_state_t state;
   eim_tmo_state_t next_state;
   logic [W-1:0]   cnt;
   logic [W-1:0]   next_cnt;
   logic           tmo;
   logic           next_tmo;
   logic           waitOn;

   if (N > 8 || W < 1) begin : g_chk
      $error("eim_timeout parameters out of range");
   end

   // An out of range select never counts
   assign waitOn = extAccessActive && (int'(extWaitSel) < N)
                   && evt.waitLevel[extWaitSel];

   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      next_tmo   = 1'b0;
      case (state)
         TMO_IDLE: begin
            next_cnt = '0;
            if (waitOn) begin
               next_state = TMO_COUNT;
            end
         end
         TMO_COUNT: begin
            if (!waitOn) begin
               next_state = TMO_IDLE;
            end else if (cnt == maxWait) begin
               next_state = TMO_FIRED;
               next_tmo   = 1'b1;
            end else begin
               next_cnt = cnt + W'(1);
            end
         end
         TMO_FIRED: begin
            // One timeout per access
            if (!extAccessActive) begin
               next_state = TMO_IDLE;
            end
         end
         default: next_state = TMO_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= TMO_IDLE;
         cnt   <= '0;
         tmo   <= 1'b0;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
         tmo   <= next_tmo;
      end
   end

   assign evt.timeout = tmo;
endmodule
`default_nettype wire

/* core/eim_irq_mask.sv */
// Overview of operation
// - Wait rises 5..2 set enabled masked bits
// - Extended wait overrun sets enabled masked timeout
// - Disabled source keeps masked bit zero, no interrupt
// - W1C masked wait bit clears raw too
// - W1C masked timeout clears raw timeout too
// - Writing zero leaves status unchanged
// - Reserved bits read zero, write zero
// - W1S enable sets wait-rise enable
// - Only clear register clears an enable
// - Writing zero to set register does nothing
// - New masked bit pulses interrupt line
// - Raw bits set regardless of enables
// - W1S enable bit 0 enables timeout
`timescale 1ns/1ps
`default_nettype none
module eim_irq_mask
   import eim_pkg::*;
#(
   parameter int N = NUM_WAIT,
   parameter int W = MAXW_W
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              arst_n,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Memory wait pins
   input  wire logic [N-1:0]      memWait,
   // Access state from the sequencer
   input  wire logic              extAccessActive,
   input  wire logic [2:0]        extWaitSel,
   // Interrupt
   output logic                   irqPulse,
   output logic                   irqLevel
);
   logic [5:0]   rawStatus;
   logic [5:0]   next_rawStatus;
   logic [5:0]   maskedStatus;
   logic [5:0]   next_maskedStatus;
   logic [5:0]   enable;
   logic [5:0]   next_enable;
   logic [W-1:0] maxWait;
   logic [W-1:0] next_maxWait;
   logic [31:0]  next_prdata;
   logic         next_irqPulse;

   logic         apbWrite;
   logic         apbSetup;
   eim_reg_t     selReg;
   logic [5:0]   wData;
   logic [5:0]   stClr;
   logic [5:0]   enSet;
   logic [5:0]   enClr;
   logic [5:0]   rawSet;
   logic [5:0]   mskSet;
   logic [31:0]  readVal;

   // Every assertion below runs on the one clock and is off during reset
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   if (ADDR_W < 5 || ADDR_W > 8 || W > 32 || N < 6) begin : g_chk
      $error("eim_irq_mask parameters out of range");
   end

   eim_evt_if #(.N(N)) evt ();

   eim_wait_edge #(.N(N)) u_edge (
      .clk     (clk),
      .arst_n  (arst_n),
      .memWait (memWait),
      .evt     (evt.edge_src)
   );

   eim_timeout #(.N(N), .W(W)) u_tmo (
      .clk             (clk),
      .arst_n          (arst_n),
      .extAccessActive (extAccessActive),
      .extWaitSel      (extWaitSel),
      .maxWait         (maxWait),
      .evt             (evt.tmo_src)
   );

   // Bus decode
   assign selReg   = eim_decode(8'(paddr));
   assign apbWrite = psel && penable && pwrite;
   assign apbSetup = psel && !penable;
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && (selReg == REG_NONE);

   // Reserved positions of written data are dropped
   assign wData = pwdata[5:0] & FIELD_MASK;

   always_comb begin
      stClr = '0;
      enSet = '0;
      enClr = '0;
      if (apbWrite) begin
         case (selReg)
            REG_RAW:    stClr = wData;
            REG_MASKED: stClr = wData;
            REG_ENSET:  enSet = wData;
            REG_ENCLR:  enClr = wData;
            default:    ;
         endcase
      end
   end

   // Raw bit 2 follows wait 0, masked bit 2 follows wait 2
   assign rawSet = {evt.waitRise[5], evt.waitRise[4],
                    evt.waitRise[3], evt.waitRise[0],
                    1'b0, evt.timeout};

   // Enables of the coming cycle gate the sets, so a source being
   // disabled never leaves a masked bit behind
   assign mskSet = {evt.waitRise[5:2], 1'b0, evt.timeout}
                   & next_enable;

   always_comb begin
      next_enable = (enable | enSet) & ~enClr;
      next_enable = next_enable & FIELD_MASK;
   end

   // Set wins over clear on the same edge
   always_comb begin
      next_rawStatus    = (rawStatus & ~stClr) | rawSet;
      next_rawStatus    = next_rawStatus & FIELD_MASK;
      next_maskedStatus = (maskedStatus & ~stClr & next_enable)
                          | mskSet;
      next_irqPulse     = |(next_maskedStatus & ~maskedStatus);
   end

   always_comb begin
      next_maxWait = maxWait;
      if (apbWrite && selReg == REG_CFG) begin
         next_maxWait = pwdata[W-1:0];
      end
   end

   always_comb begin
      readVal = '0;
      case (selReg)
         REG_RAW:    readVal[5:0] = rawStatus;
         REG_MASKED: readVal[5:0] = maskedStatus;
         REG_ENSET:  readVal[5:0] = enable;
         REG_ENCLR:  readVal[5:0] = enable;
         REG_CFG:    readVal[W-1:0] = maxWait;
         default:    readVal = '0;
      endcase
   end

   // Read data is captured in the setup cycle so prdata is a flop
   // and the slave still answers without a wait state
   always_comb begin
      next_prdata = prdata;
      if (apbSetup && !pwrite) begin
         next_prdata = readVal;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rawStatus    <= STAT_RST;
         maskedStatus <= STAT_RST;
         enable       <= EN_RST;
         maxWait      <= W'(MAXW_RST);
         prdata       <= '0;
         irqPulse     <= 1'b0;
      end else begin
         rawStatus    <= next_rawStatus;
         maskedStatus <= next_maskedStatus;
         enable       <= next_enable;
         maxWait      <= next_maxWait;
         prdata       <= next_prdata;
         irqPulse     <= next_irqPulse;
      end
   end

   assign irqLevel = |maskedStatus;

   sequence s_wr(eim_reg_t r, int b);
      apbWrite && selReg == r && pwdata[b];
   endsequence

   sequence s_no_evt(int b);
      !rawSet[b] && !mskSet[b];
   endsequence

   a_mask_gate:
   assert property ((maskedStatus & ~enable) == 6'h00)
      else $error("masked bit set while source disabled");

   a_rise_masked:
   assert property (evt.waitRise[2] && enable[2] && !enClr[2]
                    |=> maskedStatus[2] && irqLevel)
      else $error("wait 2 rise did not set masked bit");

   a_rise_raw:
   assert property (evt.waitRise[0] && !enable[2]
                    |=> rawStatus[2] && !maskedStatus[2] || enable[2])
      else $error("wait 0 rise did not set raw bit");

   a_tmo_set:
   assert property (evt.timeout && enable[0] && !enClr[0]
                    |=> maskedStatus[0] && rawStatus[0])
      else $error("timeout not recorded");

   a_w1c_both:
   assert property (s_wr(REG_MASKED, 3) ##0 s_no_evt(3)
                    |=> !maskedStatus[3] && !rawStatus[3])
      else $error("masked write one did not clear both");

   a_w1c_tmo:
   assert property (s_wr(REG_MASKED, 0) ##0 s_no_evt(0)
                    |=> !maskedStatus[0] && !rawStatus[0])
      else $error("timeout write one did not clear both");

   a_w0_keep:
   assert property (apbWrite && selReg == REG_RAW && wData == 6'h00
                    |=> (rawStatus & $past(rawStatus))
                        == $past(rawStatus))
      else $error("zero write changed raw status");

   a_rsvd_zero:
   assert property (!rawStatus[1] && !maskedStatus[1] && !enable[1]
                    && rawStatus == (rawStatus & FIELD_MASK))
      else $error("reserved bit became set");

   a_en_set:
   assert property (s_wr(REG_ENSET, 4) |=> enable[4] ##1 enable[4]
                    || $past(enClr[4]))
      else $error("enable set write failed");

   a_en_hold:
   assert property (!(apbWrite && selReg == REG_ENCLR)
                    |=> (enable & $past(enable)) == $past(enable))
      else $error("enable cleared without clear write");

   a_tmo_en:
   assert property (s_wr(REG_ENSET, 0) |=> enable[0])
      else $error("timeout enable not set");

   a_irq_pulse:
   assert property (irqPulse == |(maskedStatus & ~$past(maskedStatus)))
      else $error("interrupt pulse does not match new bits");

   a_irq_new:
   assert property (|mskSet && !(|(maskedStatus & mskSet))
                    |=> irqPulse ##1 !irqPulse || |$past(mskSet))
      else $error("new masked event gave no pulse");

   sequence s_zero_wr(eim_reg_t r);
      apbWrite && selReg == r && wData == 6'h00;
   endsequence

   sequence s_rd_setup;
      apbSetup && !pwrite && selReg != REG_CFG;
   endsequence

   a_raw_record:
   assert property (|rawSet
                    |=> (rawStatus & $past(rawSet)) == $past(rawSet))
      else $error("raw status missed an event");

   a_w0_masked:
   assert property (s_zero_wr(REG_MASKED)
                    |=> (maskedStatus & $past(maskedStatus))
                        == $past(maskedStatus))
      else $error("zero write changed masked status");

   a_en_w0:
   assert property (s_zero_wr(REG_ENSET) |=> enable == $past(enable))
      else $error("zero write to set register changed enables");

   a_en_clr:
   assert property (s_wr(REG_ENCLR, 3)
                    |=> !enable[3] && !maskedStatus[3])
      else $error("clear write left enable or masked bit");

   a_tmo_masked_off:
   assert property (evt.timeout && !enable[0] && !enSet[0]
                    |=> !maskedStatus[0] && rawStatus[0])
      else $error("disabled timeout reached masked status");

   a_tmo_single:
   assert property (evt.timeout |=> !evt.timeout)
      else $error("timeout event lasted more than one cycle");

   a_w1c_cross:
   assert property (s_wr(REG_MASKED, 2) ##0 s_no_evt(2)
                    |=> !maskedStatus[2] && !rawStatus[2])
      else $error("masked bit 2 write did not clear raw bit 2");

   a_rsvd_read:
   assert property (s_rd_setup |=> prdata[31:6] == 26'h0 && !prdata[1])
      else $error("reserved read bits not zero");

   a_pulse_level:
   assert property (irqPulse |-> irqLevel)
      else $error("interrupt pulse without masked status");
endmodule
`default_nettype wire

/* testbench/eim_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
module eim_far_model
   import eim_pkg::*;
(
   // Clock and interrupt from the block
   input  wire logic           clk,
   input  wire logic           irqPulse,
   // Wait pins and access state
   output logic [NUM_WAIT-1:0] memWait,
   output logic                extAccessActive,
   output logic [2:0]          extWaitSel,
   // Pulses seen by the interrupt controller
   output int                  pulseCount
);
   initial begin
      memWait = '0;
      extAccessActive = 1'b0;
      extWaitSel = 3'h0;
      pulseCount = 0;
   end

   // A stuck pulse counts once per cycle, so it shows up as extra pulses
   always @(posedge clk) begin
      if (irqPulse === 1'b1) begin
         pulseCount <= pulseCount + 1;
      end
   end

   // Pins rise together, hold past the synchroniser, then fall
   task automatic rise(input logic [NUM_WAIT-1:0] pins);
      @(posedge clk);
      memWait <= pins;
      repeat (4) @(posedge clk);
      memWait <= '0;
      repeat (8) @(posedge clk);
   endtask

   // One extended access whose wait pin stays active for n cycles
   task automatic tmo(input logic [2:0] sel, input int n);
      @(posedge clk);
      extWaitSel <= sel;
      extAccessActive <= 1'b1;
      memWait[sel] <= 1'b1;
      repeat (n) @(posedge clk);
      extAccessActive <= 1'b0;
      memWait <= '0;
      repeat (8) @(posedge clk);
   endtask
endmodule
`default_nettype wire

/* testbench/ext_mem_wait_irq_mask_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ext_mem_wait_irq_mask_tb_top
   import eim_pkg::*;
;
   logic                clk = 1'b0;
   logic                arst_n;
   logic                psel, penable, pwrite;
   logic [ADDR_W-1:0]   paddr;
   logic [31:0]         pwdata, prdata, rd, v, m, fm;
   logic                pready, pslverr, irqPulse, irqLevel, err;
   logic [NUM_WAIT-1:0] memWait, pins;
   logic                extAccessActive;
   logic [2:0]          extWaitSel;
   int                  pulseCount, badCount, checks, cnt;

   always #20 clk = ~clk;

   eim_irq_mask DUT (.clk(clk), .arst_n(arst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .memWait(memWait), .extAccessActive(extAccessActive),
      .extWaitSel(extWaitSel), .irqPulse(irqPulse), .irqLevel(irqLevel));

   eim_far_model u_far (.clk(clk), .irqPulse(irqPulse), .memWait(memWait),
      .extAccessActive(extAccessActive), .extWaitSel(extWaitSel),
      .pulseCount(pulseCount));

   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         badCount++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, badCount);
      if (badCount == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait that never gets an answer
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Raw wait bits follow pins 5,4,3,0; masked ones pins 5,4,3,2
   function automatic logic [31:0] expRaw(input logic [5:0] p);
      return {26'h0, p[5:3], p[0], 2'h0};
   endfunction

   function automatic logic [31:0] expMask(input logic [5:0] p,
                                           input logic [31:0] en);
      return {26'h0, p[5:2], 2'h0} & en;
   endfunction

   initial begin
      #2_000_000;
      badCount++;
      print_verdict();
   end

   initial begin
      arst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      fm = {26'h0, FIELD_MASK};
      void'($urandom(32'h2d07));
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         chk("reset value", rd, i == 4 ? {24'h0, MAXW_RST} : 32'h0);
      end
      apb(1'b0, 8'h14, 32'h0);
      chk("unmapped error", {31'h0, err}, 32'h1);
      chk("unmapped read", rd, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         v = $urandom & fm;
         apb(1'b1, ENCLR_OFS, fm);
         apb(1'b1, ENSET_OFS, v);
         apb(1'b1, ENSET_OFS, 32'h0);
         apb(1'b0, ENSET_OFS, 32'h0);
         chk("enable set", rd, v);
         apb(1'b0, ENCLR_OFS, 32'h0);
         chk("enable clear view", rd, v);
         apb(1'b1, ENCLR_OFS, v & 32'h4);
         apb(1'b0, ENSET_OFS, 32'h0);
         chk("enable one cleared", rd, v & ~32'h4);
      end
      $display("test enables done");
      for (int i = 0; i < 12; i++) begin
         v = (i == 0) ? fm : ($urandom & fm);
         pins = (i == 0) ? 6'h3F : 6'($urandom);
         m = expMask(pins, v);
         apb(1'b1, ENCLR_OFS, fm);
         apb(1'b1, ENSET_OFS, v);
         cnt = pulseCount;
         u_far.rise(pins);
         apb(1'b0, RAW_OFS, 32'h0);
         chk("raw", rd, expRaw(pins));
         apb(1'b0, MASKED_OFS, 32'h0);
         chk("masked", rd, m);
         chk("level", {31'h0, irqLevel}, {31'h0, m != 0});
         chk("pulses", 32'(pulseCount - cnt), {31'h0, m != 0});
         apb(1'b1, MASKED_OFS, 32'h0);
         apb(1'b0, MASKED_OFS, 32'h0);
         chk("zero write", rd, m);
         apb(1'b0, RAW_OFS, 32'h0);
         chk("zero write raw", rd, expRaw(pins));
         // Only the set bits are written, so raw bits left over show
         // whether each clear reached the matching raw position
         apb(1'b1, MASKED_OFS, m);
         apb(1'b0, RAW_OFS, 32'h0);
         chk("raw after", rd, expRaw(pins) & ~m);
         apb(1'b0, MASKED_OFS, 32'h0);
         chk("masked after", rd, 32'h0);
         apb(1'b1, RAW_OFS, fm);
      end
      $display("test wait rise done");
      apb(1'b1, CFG_OFS, 32'h4);
      for (int e = 0; e < 3; e++) begin
         apb(1'b1, ENCLR_OFS, fm);
         apb(1'b1, ENSET_OFS, {31'h0, e != 0});
         cnt = pulseCount;
         // The last access drops its pin before the count is reached
         u_far.tmo(3'($urandom_range(5, 0)), (e == 2) ? 3 : 20);
         apb(1'b0, RAW_OFS, 32'h0);
         chk("raw timeout", rd & 32'h1, {31'h0, e < 2});
         apb(1'b0, MASKED_OFS, 32'h0);
         chk("masked timeout", rd, {31'h0, e == 1});
         chk("tmo pulse", 32'(pulseCount - cnt), {31'h0, e == 1});
         apb(1'b1, MASKED_OFS, 32'h1);
         apb(1'b0, RAW_OFS, 32'h0);
         chk("raw tmo clr", rd & 32'h1, 32'h0);
         chk("level off", {31'h0, irqLevel}, 32'h0);
         apb(1'b1, RAW_OFS, fm);
      end
      $display("test timeout done");
      print_verdict();
   end
endmodule
`default_nettype wire
